// ### pkg/tsc_pkg.sv
// Purpose: shared constants for the telemetry scan controller
// Assumes: 20 MHz system clock, telemetry serial clock derived by division
// Notes:   command word layouts are local choices
`default_nettype none
package tsc_pkg;
  // clock rates and derived counts
  localparam int unsigned SYS_PERIOD_NS   = 50;
  localparam int unsigned SYS_HZ          = 20_000_000;
  localparam int unsigned TSCLK_HZ        = 5_000_000;
  localparam int unsigned SCLK_DIV        = SYS_HZ / TSCLK_HZ;
  localparam int unsigned MS_NS           = 1_000_000;
  localparam int unsigned MS_CYC_DEF      = MS_NS / SYS_PERIOD_NS;
  localparam int unsigned SCAN_INT_TYP_MS = 1000;
  // frame shape
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned RESULT_BITS     = 12;
  localparam int unsigned RESULT_LSB      = 4;
  localparam int unsigned GAP_CYC         = 4;
  // channel map
  localparam int unsigned MUX_CH          = 32;
  localparam int unsigned NUM_MUX         = 2;
  localparam int unsigned NUM_CONV        = 3;
  localparam int unsigned NUM_GROUPS      = 4;
  localparam int unsigned DAC_ATTR_BASE   = 64;
  localparam int unsigned NUM_ATTR        = 68;
  // command words
  localparam logic [15:0] CONV_CMD_BASE   = 16'h8000;
  localparam int unsigned CONV_SEL_BIT    = 13;
  localparam logic [15:0] MUX_CMD_BASE    = 16'h0020;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_MUX   = 3'b001,
    ST_CONV  = 3'b010,
    ST_GRP   = 3'b011,
    ST_FLUSH = 3'b100
  } tsc_state_t;
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01,
    FR_GAP   = 2'b10
  } tsc_fr_state_t;
endpackage
`default_nettype wire

// ### hdl/tsc_frame.sv
// Purpose: 16-bit serial frame engine with generated serial clock
// Assumes: partner samples on rising edge and drives on falling edge
// Notes:   one frame line per lane when NFR equals LANES
`timescale 1ns/1ns
`default_nettype none
module tsc_frame #(
  parameter int unsigned LANES = 1,
  parameter int unsigned NFR   = 1
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        start,
  input  wire logic [NFR-1:0]              frame_mask,
  input  wire logic [LANES-1:0][15:0]      tx_word,
  input  wire logic [LANES-1:0]            sdi,
  output logic                             sclk,
  output logic [LANES-1:0]                 sdo,
  output logic [NFR-1:0]                   frame_n,
  output logic [LANES-1:0][15:0]           rx_word,
  output logic                             busy,
  output logic                             done
);
  import tsc_pkg::*;
  tsc_fr_state_t             st_r;
  logic [1:0]                cnt_r;
  logic [3:0]                bit_r;
  logic [2:0]                gap_r;
  logic [LANES-1:0][15:0]    tx_r;
  logic [LANES-1:0]          s1_r;
  logic [LANES-1:0]          s2_r;

  assign busy = (st_r != FR_IDLE);
  // only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= sdi;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= FR_IDLE;
      cnt_r   <= 2'd0;
      bit_r   <= 4'd0;
      gap_r   <= 3'd0;
      tx_r    <= '0;
      rx_word <= '0;
      sclk    <= 1'b0;
      frame_n <= '1;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_r)
        FR_IDLE: begin
          sclk <= 1'b0;
          if (start) begin
            tx_r    <= tx_word;
            frame_n <= ~frame_mask;
            cnt_r   <= 2'd0;
            bit_r   <= 4'd0;
            st_r    <= FR_SHIFT;
          end
        end
        FR_SHIFT: begin
          cnt_r <= cnt_r + 2'd1;
          sclk  <= (cnt_r == 2'd1) || (cnt_r == 2'd2);
          if (cnt_r == 2'(SCLK_DIV - 1)) begin
            // sample late: synchroniser adds two cycles
            for (int l = 0; l < LANES; l++) begin
              rx_word[l] <= {rx_word[l][14:0], s2_r[l]};
              tx_r[l]    <= {tx_r[l][14:0], 1'b0};
            end
            if (bit_r == 4'(FRAME_BITS - 1)) begin
              st_r  <= FR_GAP;
              gap_r <= 3'd0;
            end else begin
              bit_r <= bit_r + 4'd1;
            end
          end
        end
        FR_GAP: begin
          frame_n <= '1;
          sclk    <= 1'b0;
          gap_r   <= gap_r + 3'd1;
          if (gap_r == 3'(GAP_CYC - 1)) begin
            st_r <= FR_IDLE;
            done <= 1'b1;
          end
        end
        default: st_r <= FR_IDLE;
      endcase
    end
  end

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      sdo[l] = (st_r == FR_SHIFT) && tx_r[l][15];
    end
  end

  // helper: length of the low frame window
  logic [7:0] low_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_r <= 8'd0;
    end else if (&frame_n) begin
      low_cnt_r <= 8'd0;
    end else begin
      low_cnt_r <= low_cnt_r + 8'd1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_frame_len;
    $rose(&frame_n) |-> $past(low_cnt_r) == 8'd64;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 16 periods");
  property p_sclk_high;
    $rose(sclk) |-> ##1 sclk ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("serial clock duty wrong");
  property p_sclk_idle;
    (st_r == FR_IDLE) |-> !sclk && (&frame_n);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock or frame active when idle");
  property p_done_gap;
    done |-> (&frame_n) && $past(st_r) == FR_GAP;
  endproperty
  a_done_gap: assert property (p_done_gap) else $error("done outside gap");
  c_frame: cover property ($rose(&frame_n));
endmodule
`default_nettype wire

// ### hdl/tsc_top.sv
// Purpose: telemetry scan controller for the front-end board
// Assumes: settings and readout flag come from outside this clock domain
// Notes:   attributes are read through a registered address/data port
// Function
// - multiplexor channels are selected over the shared DAC clock and data lines, one frame line per 32-channel multiplexor.
// - each converter gets the telemetry serial clock, a command line and its own frame line, and has two inputs that the command picks between.
// - a conversion is started by shifting a 16-bit command that also selects the input.
// - each result is read in the next sixteen-period frame while the next conversion runs.
// - the telemetry serial clock runs at 5 MHz and a full scan takes about 0.45 ms.
// - all 64 multiplexor channels are scanned periodically into readable attributes; the DAC channels are read only by group reads.
// - the time between scans comes from the scan-interval setting, usually 1000 ms.
// - scanning is held off while pixel readout is active, except for the group frames launched in ST_GRP.
// - four DAC channels are read through two further converters reporting half the DAC value.
// - an interval of zero stops periodic scans and enables group reads from the scan-command setting.
// - up to two groups are read at once on parallel converter lines.
`timescale 1ns/1ns
`default_nettype none
module tsc_top #(
  parameter int unsigned MS_CYC = tsc_pkg::MS_CYC_DEF
) (
  input  wire logic                           SYS_CLK,
  input  wire logic                           RST_N,
  input  wire logic [15:0]                    SCAN_INTERVAL_SETTING,
  input  wire logic [tsc_pkg::NUM_GROUPS-1:0] SCAN_COMMAND_SETTING,
  input  wire logic                           SCAN_COMMAND_STROBE,
  input  wire logic                           READOUT_ACTIVE,
  input  wire logic [6:0]                     ATTR_RD_ADDR,
  output logic [11:0]                         ATTR_RD_DATA,
  output logic                                SCAN_BUSY,
  output logic                                SHARED_DAC_SERIAL_CLOCK,
  output logic                                SHARED_DAC_SERIAL_IN,
  output logic [tsc_pkg::NUM_MUX-1:0]         MUX_FRAME_SELECT_N,
  output logic                                TELE_SERIAL_CLOCK,
  output logic [tsc_pkg::NUM_CONV-1:0]        TELE_CONVERTER_CMD_IN,
  output logic [tsc_pkg::NUM_CONV-1:0]        TELE_CONVERTER_FRAME_N,
  input  wire logic [tsc_pkg::NUM_CONV-1:0]   TELE_CONVERTER_DOUT
);
  import tsc_pkg::*;
  tsc_state_t              st_r;
  logic                    ro1_r, ro_s_r;
  logic [15:0]             int1_r, int_s_r;
  logic [NUM_GROUPS-1:0]   grp_r;
  logic [NUM_GROUPS-1:0]   cmd1_r, cmd_s_r;
  logic                    grp_pend_r;
  logic                    cs1_r, cs2_r, cs3_r;
  logic [$clog2(MS_CYC)-1:0] ms_cnt_r;
  logic [15:0]             elapsed_r;
  logic [4:0]              pos_r;
  logic                    mux_sel_r, in_sel_r;
  logic [NUM_CONV-1:0]     pend_r;
  logic                    pend_in_r;
  logic [4:0]              pend_pos_r;
  logic                    mux_go, conv_go, mux_done, conv_done, mux_busy, conv_busy;
  logic [NUM_CONV-1:0]     conv_mask, conv_new;
  logic [NUM_CONV-1:0][15:0] conv_tx, conv_rx;
  logic [0:0][15:0]        mux_tx;
  logic [11:0]             attr_r [NUM_ATTR];

  // settings and readout flag cross in through two flops
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ro1_r   <= 1'b0;
      ro_s_r  <= 1'b0;
      int1_r  <= 16'h0000;
      int_s_r <= 16'h0000;
      cs1_r   <= 1'b0;
      cs2_r   <= 1'b0;
      cs3_r   <= 1'b0;
      cmd1_r  <= '0;
      cmd_s_r <= '0;
    end else begin
      ro1_r   <= READOUT_ACTIVE;
      ro_s_r  <= ro1_r;
      int1_r  <= SCAN_INTERVAL_SETTING;
      int_s_r <= int1_r;
      cs1_r   <= SCAN_COMMAND_STROBE;
      cs2_r   <= cs1_r;
      cs3_r   <= cs2_r;
      cmd1_r  <= SCAN_COMMAND_SETTING;
      cmd_s_r <= cmd1_r;
    end
  end

  // group request latch; a new strobe wins over the clear on acceptance
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      grp_pend_r <= 1'b0;
      grp_r      <= '0;
    end else if (cs2_r && !cs3_r && (int_s_r == 16'h0000)) begin
      grp_pend_r <= |cmd_s_r;
      grp_r      <= cmd_s_r;
    end else if (st_r == ST_IDLE && grp_pend_r && !ro_s_r) begin
      grp_pend_r <= 1'b0;
    end
  end

  // millisecond base and time since last scan
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt_r  <= '0;
      elapsed_r <= 16'h0000;
    end else if (st_r != ST_IDLE) begin
      ms_cnt_r  <= '0;
      elapsed_r <= 16'h0000;
    end else if (ms_cnt_r == ($clog2(MS_CYC))'(MS_CYC - 1)) begin
      ms_cnt_r  <= '0;
      elapsed_r <= (elapsed_r == 16'hFFFF) ? elapsed_r : elapsed_r + 16'h0001;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  // launches are held while pixels are read out, except the group frames of ST_GRP
  always_comb begin
    mux_go    = (st_r == ST_MUX) && !mux_busy && !mux_done && !ro_s_r;
    conv_go  = 1'b0;
    conv_new = '0;
    case (st_r)
      ST_CONV: begin
        conv_go  = !conv_busy && !conv_done && !ro_s_r;
        conv_new = 3'b001;
      end
      ST_GRP: begin
        conv_go  = !conv_busy && !conv_done;
        conv_new = {grp_r[{1'b1, in_sel_r}], grp_r[{1'b0, in_sel_r}], 1'b0};
      end
      ST_FLUSH: begin
        conv_go  = !conv_busy && !conv_done && (pend_r != '0) && !ro_s_r;
        conv_new = '0;
      end
      default: begin
        conv_go  = 1'b0;
        conv_new = '0;
      end
    endcase
    // a lane owing a result is framed again, else its data never comes out
    conv_mask = conv_new | pend_r;
  end

  always_comb begin
    for (int c = 0; c < NUM_CONV; c++) begin
      conv_tx[c] = CONV_CMD_BASE;
      conv_tx[c][CONV_SEL_BIT] = in_sel_r;
    end
    mux_tx[0] = MUX_CMD_BASE | {11'h000, pos_r};
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r       <= ST_IDLE;
      pos_r      <= 5'd0;
      mux_sel_r  <= 1'b0;
      in_sel_r   <= 1'b0;
      pend_r     <= '0;
      pend_in_r  <= 1'b0;
      pend_pos_r <= 5'd0;
    end else begin
      if (conv_done) begin
        pend_r     <= (st_r == ST_FLUSH) ? '0 : conv_new;
        pend_in_r  <= in_sel_r;
        pend_pos_r <= pos_r;
      end
      case (st_r)
        ST_IDLE: begin
          pos_r     <= 5'd0;
          mux_sel_r <= 1'b0;
          in_sel_r  <= 1'b0;
          if (int_s_r != 16'h0000 && elapsed_r >= int_s_r && !ro_s_r) begin
            st_r <= ST_MUX;
          end else if (int_s_r == 16'h0000 && grp_pend_r && !ro_s_r) begin
            st_r <= ST_GRP;
          end
        end
        ST_MUX: begin
          if (mux_done) begin
            mux_sel_r <= ~mux_sel_r;
            if (mux_sel_r) begin
              st_r <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            in_sel_r <= ~in_sel_r;
            if (in_sel_r) begin
              pos_r <= pos_r + 5'd1;
              st_r  <= (pos_r == 5'(MUX_CH - 1)) ? ST_FLUSH : ST_MUX;
            end
          end
        end
        ST_GRP: begin
          if (conv_done) begin
            in_sel_r <= ~in_sel_r;
            if (in_sel_r) begin
              st_r <= ST_FLUSH;
            end
          end
        end
        ST_FLUSH: begin
          if (conv_done || pend_r == '0) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // attribute store: one writer per entry, fed by the frame that returns the result
  logic [NUM_ATTR-1:0] attr_we;
  for (genvar e = 0; e < NUM_ATTR; e++) begin : g_attr
    localparam logic [6:0] EI = 7'(e);
    assign attr_we[e] = conv_done && (
        (pend_r[0] && EI == {1'b0, pend_in_r, pend_pos_r}) ||
        (pend_r[1] && EI == 7'(DAC_ATTR_BASE) + {6'd0, pend_in_r}) ||
        (pend_r[2] && EI == 7'(DAC_ATTR_BASE + 2) + {6'd0, pend_in_r}));
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
        attr_r[e] <= 12'h000;
      end else if (attr_we[e]) begin
        attr_r[e] <= conv_rx[(e < DAC_ATTR_BASE) ? 0 : ((e < DAC_ATTR_BASE + 2) ? 1 : 2)]
                     [RESULT_LSB +: RESULT_BITS];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ATTR_RD_DATA <= 12'h000;
    end else begin
      ATTR_RD_DATA <= (ATTR_RD_ADDR < 7'(NUM_ATTR)) ? attr_r[ATTR_RD_ADDR] : 12'h000;
    end
  end
  assign SCAN_BUSY = (st_r != ST_IDLE);

  tsc_frame #(.LANES(1), .NFR(NUM_MUX)) u_mux (
    .clk        (SYS_CLK),
    .rst_n      (RST_N),
    .start      (mux_go),
    .frame_mask ({mux_sel_r, ~mux_sel_r}),
    .tx_word    (mux_tx),
    .sdi        (1'b0),
    .sclk       (SHARED_DAC_SERIAL_CLOCK),
    .sdo        (SHARED_DAC_SERIAL_IN),
    .frame_n    (MUX_FRAME_SELECT_N),
    .rx_word    (),
    .busy       (mux_busy),
    .done       (mux_done)
  );
  tsc_frame #(.LANES(NUM_CONV), .NFR(NUM_CONV)) u_conv (
    .clk        (SYS_CLK),
    .rst_n      (RST_N),
    .start      (conv_go),
    .frame_mask (conv_mask),
    .tx_word    (conv_tx),
    .sdi        (TELE_CONVERTER_DOUT),
    .sclk       (TELE_SERIAL_CLOCK),
    .sdo        (TELE_CONVERTER_CMD_IN),
    .frame_n    (TELE_CONVERTER_FRAME_N),
    .rx_word    (conv_rx),
    .busy       (conv_busy),
    .done       (conv_done)
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_suspend;
    ro_s_r && (st_r == ST_MUX || st_r == ST_CONV || st_r == ST_FLUSH) |-> !mux_go && !conv_go;
  endproperty
  a_suspend: assert property (p_suspend) else $error("launch during readout");
  property p_zero_int;
    (st_r == ST_IDLE) && (int_s_r == 16'h0000) |=> st_r != ST_MUX;
  endproperty
  a_zero_int: assert property (p_zero_int) else $error("periodic scan with zero interval");
  property p_we_on_done;
    (|attr_we) |-> conv_done && (pend_r != '0);
  endproperty
  a_we_on_done: assert property (p_we_on_done) else $error("attribute written early");
  property p_parallel;
    conv_go && st_r == ST_GRP && grp_r[1] && grp_r[3] && in_sel_r |-> conv_mask[2:1] == 2'b11;
  endproperty
  a_parallel: assert property (p_parallel) else $error("groups not framed together");
  property p_mux_then_conv;
    (st_r == ST_MUX) && mux_done && mux_sel_r |=> st_r == ST_CONV;
  endproperty
  a_mux_then_conv: assert property (p_mux_then_conv) else $error("conversion not after mux");
  property p_pipeline;
    conv_done && pend_r[0] |-> attr_we[{1'b0, pend_in_r, pend_pos_r}];
  endproperty
  a_pipeline: assert property (p_pipeline) else $error("pending result dropped");
  c_full_scan: cover property ((st_r == ST_FLUSH) && $past(st_r) == ST_CONV);
  c_group: cover property ((st_r == ST_GRP) && conv_go && conv_mask == 3'b110);
  c_suspend: cover property (ro_s_r && st_r == ST_MUX);
endmodule
`default_nettype wire

// ### bench/tsc_far_model.sv
// Purpose: far-side model of the telemetry converters and multiplexors
// Assumes: sampling on rising serial clock, driving on falling clock
// Notes:   result code is {lane, input, 4'hA, mux channel}, with the channel field zero on lanes 1 and 2
`timescale 1ns/1ns
`default_nettype none
module tsc_far_model (
  input  wire logic        mux_clk,
  input  wire logic        mux_din,
  input  wire logic [1:0]  mux_frame_n,
  input  wire logic        conv_clk,
  input  wire logic [2:0]  conv_din,
  input  wire logic [2:0]  conv_frame_n,
  output logic [2:0]       conv_dout,
  output logic [1:0][4:0]  mux_ch,
  output logic [2:0][5:0]  conv_edges,
  output logic [2:0][15:0] conv_word
);
  logic [2:0][15:0] cmd_sr;
  logic [2:0][15:0] out_sr;
  logic [2:0][11:0] result;
  logic [1:0][15:0] mux_sr;
  logic [1:0][5:0]  mux_edges;
  logic [2:0]       conv_q;
  logic [1:0]       mux_q;
  initial begin
    conv_dout = '0;
    result    = '0;
    conv_q    = '1;
    mux_q     = '1;
    mux_ch    = '0;
  end
  always @(posedge mux_clk) begin
    for (int m = 0; m < 2; m++) begin
      if (!mux_frame_n[m]) begin
        mux_sr[m]    <= {mux_sr[m][14:0], mux_din};
        mux_edges[m] <= mux_edges[m] + 6'h01;
      end
    end
  end
  // a short word leaves the channel as it was
  always @(mux_frame_n) begin
    for (int m = 0; m < 2; m++) begin
      if (mux_q[m] && !mux_frame_n[m]) begin
        mux_edges[m] = '0;
      end else if (!mux_q[m] && mux_frame_n[m] && mux_edges[m] == 6'h10) begin
        mux_ch[m] = mux_sr[m][4:0];
      end
    end
    mux_q = mux_frame_n;
  end
  always @(posedge conv_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (!conv_frame_n[k]) begin
        cmd_sr[k]     <= {cmd_sr[k][14:0], conv_din[k]};
        conv_edges[k] <= conv_edges[k] + 6'h01;
      end
    end
  end
  // no shift at the closing edge, so the release level is not overwritten
  always @(negedge conv_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (!conv_frame_n[k] && conv_edges[k] < 6'h10) begin
        out_sr[k]    <= {out_sr[k][14:0], 1'b0};
        conv_dout[k] <= out_sr[k][14];
      end
    end
  end
  always @(conv_frame_n) begin
    for (int k = 0; k < 3; k++) begin
      if (conv_q[k] && !conv_frame_n[k]) begin
        conv_edges[k] = '0;
        out_sr[k]     = {result[k], 4'h0};
        conv_dout[k]  = result[k][11];
      end else if (!conv_q[k] && conv_frame_n[k]) begin
        // released line shows the inverse of its last bit
        conv_dout[k] = ~conv_dout[k];
        if (conv_edges[k] == 6'h10) begin
          conv_word[k] = cmd_sr[k];
          result[k]    = {k[1:0], cmd_sr[k][13], 4'hA,
                          (k == 0) ? mux_ch[cmd_sr[k][13]] : 5'h00};
        end
      end
    end
    conv_q = conv_frame_n;
  end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench for the telemetry scan controller
// Assumes: millisecond count shortened to 20 cycles
// Notes:   scan length bounded from frame timing, not the nominal figure
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tsc_pkg::*;
  localparam int MSC   = 20;
  localparam int FRC   = FRAME_BITS * SCLK_DIV;
  localparam int NFRM  = 4 * MUX_CH + 1;
  localparam int SC_LO = NFRM * (FRC + GAP_CYC);
  localparam int SC_HI = NFRM * (FRC + GAP_CYC + 3);
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] interval = 16'h0000;
  logic [3:0]  cmd = 4'h0;
  logic        strobe = 1'b0;
  logic        readout = 1'b0;
  logic [6:0]  rd_addr = 7'h00;
  logic [11:0] rd_data;
  logic        busy, dac_clk, dac_din, tel_clk;
  logic [1:0]  mux_fn;
  logic [2:0]  conv_din, conv_fn, conv_dout;
  logic [1:0][4:0]  mux_ch;
  logic [2:0][5:0]  conv_edges;
  logic [2:0][15:0] conv_word;
  int          failures = 0;
  int          n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  tsc_top #(.MS_CYC(MSC)) i_tsc_top (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .SCAN_INTERVAL_SETTING(interval),
    .SCAN_COMMAND_SETTING(cmd), .SCAN_COMMAND_STROBE(strobe),
    .READOUT_ACTIVE(readout), .ATTR_RD_ADDR(rd_addr), .ATTR_RD_DATA(rd_data),
    .SCAN_BUSY(busy), .SHARED_DAC_SERIAL_CLOCK(dac_clk),
    .SHARED_DAC_SERIAL_IN(dac_din), .MUX_FRAME_SELECT_N(mux_fn),
    .TELE_SERIAL_CLOCK(tel_clk), .TELE_CONVERTER_CMD_IN(conv_din),
    .TELE_CONVERTER_FRAME_N(conv_fn), .TELE_CONVERTER_DOUT(conv_dout));
  tsc_far_model i_tsc_far_model (
    .mux_clk(dac_clk), .mux_din(dac_din), .mux_frame_n(mux_fn),
    .conv_clk(tel_clk), .conv_din(conv_din), .conv_frame_n(conv_fn),
    .conv_dout(conv_dout), .mux_ch(mux_ch), .conv_edges(conv_edges),
    .conv_word(conv_word));
  function automatic logic [11:0] ev(input logic [1:0] k, input logic s,
                                     input logic [4:0] ch);
    return {k, s, 4'hA, ch};
  endfunction
  task automatic conclude;
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      $display("[FAIL] %0t busy wait ran out", $time);
    end
  endtask
  task automatic rd(input logic [6:0] a, output logic [11:0] d);
    @(posedge sys_clk);
    rd_addr <= a;
    cyc(2);
    d = rd_data;
  endtask
  task automatic grp(input logic [3:0] g);
    @(posedge sys_clk);
    cmd    <= g;
    strobe <= 1'b1;
    wait_busy(1'b1, 200);
    @(posedge sys_clk);
    strobe <= 1'b0;
  endtask
  task automatic t_reset;
    chk({mux_fn, conv_fn, dac_clk, tel_clk, busy, rd_data}, 32'h000F_8000, "reset");
  endtask
  task automatic t_scan;
    time ts, tf, ta;
    logic [11:0] d;
    @(posedge sys_clk);
    interval <= 16'h0002;
    wait_busy(1'b1, 4000);
    ts = $time;
    @(negedge conv_fn[0]);
    tf = $time;
    @(posedge tel_clk);
    ta = $time;
    @(posedge tel_clk);
    chk(32'($time - ta), SYS_PERIOD_NS * SCLK_DIV, "sclk period");
    @(posedge conv_fn[0]);
    chk(32'($time - tf), SYS_PERIOD_NS * (FRC + 1), "frame length");
    #1;
    chk(conv_edges[0], 6'h10, "edges per frame");
    chk(conv_word[0], CONV_CMD_BASE, "input0 command");
    wait_busy(1'b0, 12000);
    chk(32'((($time - ts) / SYS_PERIOD_NS) inside {[SC_LO:SC_HI]}), 1, "scan length");
    chk(mux_ch, 10'h3FF, "mux channel");
    for (int p = 0; p < 64; p++) begin
      rd(p[6:0], d);
      chk(d, ev(2'h0, p >= 32, p[4:0]), "scan attribute");
    end
  endtask
  task automatic t_interval;
    time te;
    for (int i = 1; i <= 2; i++) begin
      @(posedge sys_clk);
      interval <= 16'(2 * i);
      wait_busy(1'b1, 12000);
      wait_busy(1'b0, 12000);
      te = $time;
      wait_busy(1'b1, 4000);
      chk(32'((($time - te) / SYS_PERIOD_NS) inside {[(2 * i - 1) * MSC + 1:2 * i * MSC + 8]}),
          1, "scan gap");
    end
  endtask
  task automatic t_readout;
    int lows;
    lows = 0;
    @(posedge sys_clk);
    readout <= 1'b1;
    cyc(80);
    repeat (400) begin
      cyc(1);
      if (mux_fn !== 2'h3 || conv_fn !== 3'h7) lows++;
    end
    chk(lows, 0, "frame during readout");
    @(posedge sys_clk);
    readout <= 1'b0;
  endtask
  task automatic t_group;
    logic [11:0] d;
    @(posedge sys_clk);
    interval <= 16'h0000;
    wait_busy(1'b0, 12000);
    cyc(200);
    chk(busy, 1'b0, "scan with zero interval");
    grp(4'h1);
    wait_busy(1'b0, 1000);
    rd(7'h40, d);
    chk(d, ev(2'h1, 1'b0, 5'h00), "group 0");
    rd(7'h42, d);
    chk(d, 12'h000, "unrequested group");
    grp(4'hE);
    @(negedge conv_fn[1]);
    #1;
    chk(conv_fn, 3'h1, "parallel frames");
    @(posedge conv_fn[1]);
    #1;
    chk(conv_word[1], CONV_CMD_BASE | 16'h2000, "input1 command");
    wait_busy(1'b0, 1000);
    for (int q = 0; q < 4; q++) begin
      rd(7'(64 + q), d);
      chk(d, ev(2'(1 + q / 2), q[0], 5'h00), "group result");
    end
    rd(7'h64, d);
    chk(d, 12'h000, "unmapped attribute");
  endtask
  initial begin
    cyc(19);
    t_reset;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    t_scan;
    t_interval;
    t_readout;
    t_group;
    conclude;
  end
  // bound well above the four scans the sequence needs
  initial begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
